// ==== design/drmc_consts.vh ====
// constants of the drawing-mode configuration register bank
// assumes one includer per compile unit; guarded against double inclusion
`ifndef DRMC_CONSTS_VH
`define DRMC_CONSTS_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define DRMC_OFS_POLY_MODE 12'h428
`define DRMC_OFS_TEX_MODE 12'h42C
`define DRMC_OFS_BLIT_MODE 12'h430
`define DRMC_OFS_GRAY_EXT 12'h43C
`define DRMC_OFS_FRAME_ORG 12'h440
`define DRMC_OFS_FRAME_WID 12'h444
`define DRMC_OFS_DEPTH_ORG 12'h448
`define DRMC_OFS_TEXEL_ORG 12'h44C
`define DRMC_OFS_PFLAG_ORG 12'h450

// ****************************************************************
// field positions
// ****************************************************************
`define DRMC_POLY_BLEND_LSB 7
`define DRMC_POLY_PSRC_LSB 28
`define DRMC_TEX_CORR_BIT 3
`define DRMC_TEX_FILT_BIT 5
`define DRMC_TEX_WRAPT_LSB 8
`define DRMC_TEX_WRAPS_LSB 10
`define DRMC_TEX_MIX_LSB 16
`define DRMC_TEX_ALPHA_LSB 20
`define DRMC_TEX_ACCEL_BIT 24
`define DRMC_BLIT_TRANS_BIT 1
`define DRMC_BLIT_BLEND_LSB 7
`define DRMC_BLIT_LOGIC_LSB 9
`define DRMC_GRAY_MASK_BIT 4
`define DRMC_ORG_LSB 6
`define DRMC_ORG_MSB 25
`define DRMC_WID_MSB 11

// ****************************************************************
// codes and reset values
// ****************************************************************
`define DRMC_BLEND_COPY 2'h0
`define DRMC_BLEND_ALPHA 2'h1
`define DRMC_BLEND_LOGIC 2'h2
`define DRMC_TALPHA_NORMAL 2'h0
`define DRMC_PSRC_TILE 2'h1
`define DRMC_PSRC_TEXTURE 2'h2
`define DRMC_RST_LOGIC 4'h3
`define DRMC_RST_FIELD2 2'h0
`define DRMC_RST_WORD 32'h0000_0000

`endif

// ==== design/drmc_mode_decode.v ====
// derived drawing modes: effective texture alpha and pattern enables
// assumes stored mode fields arrive from flops of the register bank
`timescale 1ns/1ps
`default_nettype none
`include "drmc_consts.vh"

module drmc_mode_decode (
  input wire i_clk_sys,
  input wire i_rst,
  input wire [1:0] i_poly_blend_sel,
  input wire [1:0] i_pattern_source_sel,
  input wire [1:0] i_tex_alpha_mode,
  output reg [1:0] o_tex_alpha_eff,
  output reg o_tile_en,
  output reg o_texture_en
);

  // ****************************************************************
  // combinational decode
  // ****************************************************************
  reg [1:0] nxt_alpha;
  reg nxt_tile;
  reg nxt_tex;

  // stencil modes fall back to normal outside alpha blending
  always @* begin
    if (i_poly_blend_sel == `DRMC_BLEND_ALPHA) begin
      nxt_alpha = i_tex_alpha_mode;
    end else begin
      nxt_alpha = `DRMC_TALPHA_NORMAL;
    end
    // reserved code 11 enables neither source
    nxt_tile = (i_pattern_source_sel == `DRMC_PSRC_TILE);
    nxt_tex = (i_pattern_source_sel == `DRMC_PSRC_TEXTURE);
  end

  // ****************************************************************
  // output flops
  // ****************************************************************
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_tex_alpha_eff <= `DRMC_TALPHA_NORMAL;
      o_tile_en <= 1'b0;
      o_texture_en <= 1'b0;
    end else begin
      o_tex_alpha_eff <= nxt_alpha;
      o_tile_en <= nxt_tile;
      o_texture_en <= nxt_tex;
    end
  end

endmodule

`default_nettype wire

// ==== design/drmc_regs.v ====
// drawing-mode configuration register bank loaded from the command stream
// assumes the command decoder presents one register-load command per cycle
// and that the pixel path feeds blit pixels already aligned to the clock
`timescale 1ns/1ps
`default_nettype none
`include "drmc_consts.vh"

module drmc_regs #(
  parameter PIXEL_W = 16
) (
  input wire i_clk_sys,
  input wire i_rst,
  // register-load command from the drawing command stream
  input wire i_cmd_valid,
  input wire [11:0] i_cmd_addr,
  input wire [31:0] i_cmd_data,
  // engine-side readback of stored registers
  input wire i_rd_en,
  input wire [11:0] i_rd_addr,
  // internal update of non-mask gray extension bits
  input wire i_gray_int_we,
  input wire [31:0] i_gray_int_data,
  // blit pixel path
  input wire i_px_valid,
  input wire [PIXEL_W-1:0] i_px_data,
  input wire [PIXEL_W-1:0] i_trans_color,
  output reg o_px_we,
  output reg [PIXEL_W-1:0] o_px_data,
  // command status
  output reg o_cmd_unmapped,
  output reg o_rd_valid,
  output reg [31:0] o_rd_data,
  // texture mapping modes
  output reg o_coord_correct_en,
  output reg o_filter_select,
  output reg [1:0] o_wrap_mode_t,
  output reg [1:0] o_wrap_mode_s,
  output reg [1:0] o_texel_mix_mode,
  output reg [1:0] o_tex_alpha_mode,
  output wire [1:0] o_tex_alpha_eff,
  output reg o_tex_area_x4,
  // polygon modes
  output reg [1:0] o_pattern_source_sel,
  output reg [1:0] o_poly_blend_sel,
  output wire o_tile_en,
  output wire o_texture_en,
  // blit modes
  output reg o_transparent_skip_en,
  output reg [1:0] o_blend_sel,
  output reg [3:0] o_blit_logic_op,
  // gray extension
  output reg o_gray_shade_unmask,
  output reg [31:0] o_gray_ext,
  // buffer origins and frame width
  output reg [25:0] o_frame_origin,
  output reg [11:0] o_frame_width_px,
  output reg [25:0] o_depth_origin,
  output reg [25:0] o_texel_store_origin,
  output reg [25:0] o_poly_flag_origin
);

  localparam ORG_W = `DRMC_ORG_MSB - `DRMC_ORG_LSB + 1;

  // ****************************************************************
  // storage
  // ****************************************************************
  reg [1:0] psrc_ff;
  reg [1:0] pblend_ff;
  reg tcorr_ff;
  reg tfilt_ff;
  reg [1:0] wrapt_ff;
  reg [1:0] wraps_ff;
  reg [1:0] tmix_ff;
  reg [1:0] talpha_ff;
  reg taccel_ff;
  reg trans_ff;
  reg [1:0] bblend_ff;
  reg [3:0] blogic_ff;
  reg [31:0] gray_ff;
  reg [ORG_W-1:0] frame_org_ff;
  reg [11:0] frame_wid_ff;
  reg [ORG_W-1:0] depth_org_ff;
  reg [ORG_W-1:0] texel_org_ff;
  reg [ORG_W-1:0] pflag_org_ff;

  // ****************************************************************
  // command address decode
  // ****************************************************************
  wire wr_poly;
  wire wr_tex;
  wire wr_blit;
  wire wr_gray;
  wire wr_forg;
  wire wr_fwid;
  wire wr_dorg;
  wire wr_torg;
  wire wr_porg;
  wire wr_hit;

  // apart from the internal gray update, only the command stream writes here; no processor path exists
  assign wr_poly = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_POLY_MODE);
  assign wr_tex = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_TEX_MODE);
  assign wr_blit = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_BLIT_MODE);
  assign wr_gray = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_GRAY_EXT);
  assign wr_forg = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_FRAME_ORG);
  assign wr_fwid = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_FRAME_WID);
  assign wr_dorg = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_DEPTH_ORG);
  assign wr_torg = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_TEXEL_ORG);
  assign wr_porg = i_cmd_valid & (i_cmd_addr == `DRMC_OFS_PFLAG_ORG);
  assign wr_hit = wr_poly | wr_tex | wr_blit | wr_gray | wr_forg |
                  wr_fwid | wr_dorg | wr_torg | wr_porg;

  // ****************************************************************
  // polygon and texture mode registers
  // ****************************************************************
  // values hold until the next load, so later primitives see them
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      psrc_ff <= `DRMC_RST_FIELD2;
      pblend_ff <= `DRMC_RST_FIELD2;
      tcorr_ff <= 1'b0;
      tfilt_ff <= 1'b0;
      wrapt_ff <= `DRMC_RST_FIELD2;
      wraps_ff <= `DRMC_RST_FIELD2;
      tmix_ff <= `DRMC_RST_FIELD2;
      talpha_ff <= `DRMC_RST_FIELD2;
      taccel_ff <= 1'b0;
    end else begin
      if (wr_poly) begin
        psrc_ff <= i_cmd_data[`DRMC_POLY_PSRC_LSB+1:`DRMC_POLY_PSRC_LSB];
        pblend_ff <= i_cmd_data[`DRMC_POLY_BLEND_LSB+1:`DRMC_POLY_BLEND_LSB];
      end
      if (wr_tex) begin
        tcorr_ff <= i_cmd_data[`DRMC_TEX_CORR_BIT];
        tfilt_ff <= i_cmd_data[`DRMC_TEX_FILT_BIT];
        wrapt_ff <= i_cmd_data[`DRMC_TEX_WRAPT_LSB+1:`DRMC_TEX_WRAPT_LSB];
        wraps_ff <= i_cmd_data[`DRMC_TEX_WRAPS_LSB+1:`DRMC_TEX_WRAPS_LSB];
        tmix_ff <= i_cmd_data[`DRMC_TEX_MIX_LSB+1:`DRMC_TEX_MIX_LSB];
        talpha_ff <= i_cmd_data[`DRMC_TEX_ALPHA_LSB+1:`DRMC_TEX_ALPHA_LSB];
        taccel_ff <= i_cmd_data[`DRMC_TEX_ACCEL_BIT];
      end
    end
  end

  // ****************************************************************
  // blit mode register
  // ****************************************************************
  // blend and transparency are stored as loaded; the pairing with copy
  // blend is the controller's duty, not checked here
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      trans_ff <= 1'b0;
      bblend_ff <= `DRMC_RST_FIELD2;
      blogic_ff <= `DRMC_RST_LOGIC;
    end else if (wr_blit) begin
      trans_ff <= i_cmd_data[`DRMC_BLIT_TRANS_BIT];
      bblend_ff <= i_cmd_data[`DRMC_BLIT_BLEND_LSB+1:`DRMC_BLIT_BLEND_LSB];
      blogic_ff <= i_cmd_data[`DRMC_BLIT_LOGIC_LSB+3:`DRMC_BLIT_LOGIC_LSB];
    end
  end

  // ****************************************************************
  // gray extension register
  // ****************************************************************
  reg [31:0] nxt_gray;

  // command load first, then internal update of non-mask bits on top;
  // the mask bit belongs to the command alone; on a same-cycle clash the internal data wins all other bits
  always @* begin
    nxt_gray = gray_ff;
    if (wr_gray) begin
      nxt_gray = i_cmd_data;
    end
    if (i_gray_int_we) begin
      nxt_gray = {i_gray_int_data[31:`DRMC_GRAY_MASK_BIT+1],
                  nxt_gray[`DRMC_GRAY_MASK_BIT],
                  i_gray_int_data[`DRMC_GRAY_MASK_BIT-1:0]};
    end
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      gray_ff <= `DRMC_RST_WORD;
    end else begin
      gray_ff <= nxt_gray;
    end
  end

  // ****************************************************************
  // buffer origins and frame width
  // ****************************************************************
  // low six address bits are not stored, which forces 64-byte alignment
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      frame_org_ff <= {ORG_W{1'b0}};
      frame_wid_ff <= 12'h000;
      depth_org_ff <= {ORG_W{1'b0}};
      texel_org_ff <= {ORG_W{1'b0}};
      pflag_org_ff <= {ORG_W{1'b0}};
    end else begin
      if (wr_forg) begin
        frame_org_ff <= i_cmd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB];
      end
      if (wr_fwid) begin
        frame_wid_ff <= i_cmd_data[`DRMC_WID_MSB:0];
      end
      if (wr_dorg) begin
        depth_org_ff <= i_cmd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB];
      end
      if (wr_torg) begin
        texel_org_ff <= i_cmd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB];
      end
      if (wr_porg) begin
        pflag_org_ff <= i_cmd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB];
      end
    end
  end

  // ****************************************************************
  // engine readback
  // ****************************************************************
  reg [31:0] nxt_rd_data;

  // gray extension is write only and reads as zero like unmapped words
  always @* begin
    nxt_rd_data = 32'h0000_0000;
    case (i_rd_addr)
      `DRMC_OFS_POLY_MODE: begin
        nxt_rd_data[`DRMC_POLY_PSRC_LSB+1:`DRMC_POLY_PSRC_LSB] = psrc_ff;
        nxt_rd_data[`DRMC_POLY_BLEND_LSB+1:`DRMC_POLY_BLEND_LSB] = pblend_ff;
      end
      `DRMC_OFS_TEX_MODE: begin
        nxt_rd_data[`DRMC_TEX_CORR_BIT] = tcorr_ff;
        nxt_rd_data[`DRMC_TEX_FILT_BIT] = tfilt_ff;
        nxt_rd_data[`DRMC_TEX_WRAPT_LSB+1:`DRMC_TEX_WRAPT_LSB] = wrapt_ff;
        nxt_rd_data[`DRMC_TEX_WRAPS_LSB+1:`DRMC_TEX_WRAPS_LSB] = wraps_ff;
        nxt_rd_data[`DRMC_TEX_MIX_LSB+1:`DRMC_TEX_MIX_LSB] = tmix_ff;
        nxt_rd_data[`DRMC_TEX_ALPHA_LSB+1:`DRMC_TEX_ALPHA_LSB] = talpha_ff;
        nxt_rd_data[`DRMC_TEX_ACCEL_BIT] = taccel_ff;
      end
      `DRMC_OFS_BLIT_MODE: begin
        nxt_rd_data[`DRMC_BLIT_TRANS_BIT] = trans_ff;
        nxt_rd_data[`DRMC_BLIT_BLEND_LSB+1:`DRMC_BLIT_BLEND_LSB] = bblend_ff;
        nxt_rd_data[`DRMC_BLIT_LOGIC_LSB+3:`DRMC_BLIT_LOGIC_LSB] = blogic_ff;
      end
      `DRMC_OFS_FRAME_ORG: begin
        nxt_rd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB] = frame_org_ff;
      end
      `DRMC_OFS_FRAME_WID: begin
        nxt_rd_data[`DRMC_WID_MSB:0] = frame_wid_ff;
      end
      `DRMC_OFS_DEPTH_ORG: begin
        nxt_rd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB] = depth_org_ff;
      end
      `DRMC_OFS_TEXEL_ORG: begin
        nxt_rd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB] = texel_org_ff;
      end
      `DRMC_OFS_PFLAG_ORG: begin
        nxt_rd_data[`DRMC_ORG_MSB:`DRMC_ORG_LSB] = pflag_org_ff;
      end
      default: begin
        nxt_rd_data = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rd_valid <= 1'b0;
      o_rd_data <= 32'h0000_0000;
      o_cmd_unmapped <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= nxt_rd_data;
      end
      // one-cycle flag for a load aimed outside this bank
      o_cmd_unmapped <= i_cmd_valid & ~wr_hit;
    end
  end

  // ****************************************************************
  // mode outputs
  // ****************************************************************
  // mirrored one cycle after storage so every output leaves a flop
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_coord_correct_en <= 1'b0;
      o_filter_select <= 1'b0;
      o_wrap_mode_t <= `DRMC_RST_FIELD2;
      o_wrap_mode_s <= `DRMC_RST_FIELD2;
      o_texel_mix_mode <= `DRMC_RST_FIELD2;
      o_tex_alpha_mode <= `DRMC_RST_FIELD2;
      o_tex_area_x4 <= 1'b0;
      o_pattern_source_sel <= `DRMC_RST_FIELD2;
      o_poly_blend_sel <= `DRMC_RST_FIELD2;
      o_transparent_skip_en <= 1'b0;
      o_blend_sel <= `DRMC_RST_FIELD2;
      o_blit_logic_op <= `DRMC_RST_LOGIC;
      o_gray_shade_unmask <= 1'b0;
      o_gray_ext <= `DRMC_RST_WORD;
      o_frame_origin <= 26'h000_0000;
      o_frame_width_px <= 12'h000;
      o_depth_origin <= 26'h000_0000;
      o_texel_store_origin <= 26'h000_0000;
      o_poly_flag_origin <= 26'h000_0000;
    end else begin
      o_coord_correct_en <= tcorr_ff;
      o_filter_select <= tfilt_ff;
      o_wrap_mode_t <= wrapt_ff;
      o_wrap_mode_s <= wraps_ff;
      o_texel_mix_mode <= tmix_ff;
      o_tex_alpha_mode <= talpha_ff;
      o_tex_area_x4 <= taccel_ff;
      o_pattern_source_sel <= psrc_ff;
      o_poly_blend_sel <= pblend_ff;
      o_transparent_skip_en <= trans_ff;
      o_blend_sel <= bblend_ff;
      o_blit_logic_op <= blogic_ff;
      o_gray_shade_unmask <= gray_ff[`DRMC_GRAY_MASK_BIT];
      o_gray_ext <= gray_ff;
      o_frame_origin <= {frame_org_ff, 6'h00};
      o_frame_width_px <= frame_wid_ff;
      o_depth_origin <= {depth_org_ff, 6'h00};
      o_texel_store_origin <= {texel_org_ff, 6'h00};
      o_poly_flag_origin <= {pflag_org_ff, 6'h00};
    end
  end

  // ****************************************************************
  // transparent blit pixel filter
  // ****************************************************************
  // compare uses the stored enable so a load takes effect next pixel
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_px_we <= 1'b0;
      o_px_data <= {PIXEL_W{1'b0}};
    end else begin
      o_px_we <= i_px_valid & ~(trans_ff & (i_px_data == i_trans_color));
      o_px_data <= i_px_data;
    end
  end

  // ****************************************************************
  // derived modes
  // ****************************************************************
  drmc_mode_decode u_decode (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_poly_blend_sel(pblend_ff),
    .i_pattern_source_sel(psrc_ff),
    .i_tex_alpha_mode(talpha_ff),
    .o_tex_alpha_eff(o_tex_alpha_eff),
    .o_tile_en(o_tile_en),
    .o_texture_en(o_texture_en)
  );

endmodule

`default_nettype wire

// ==== tb/drmc_regs_sva.sv ====
// checker: port behaviour of the drawing-mode register bank
// assumes binding onto drmc_regs, one clock, sync active-high reset
`timescale 1ns/1ps
`default_nettype none

module drmc_regs_sva #(
  parameter PIXEL_W = 16
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_cmd_valid,
  input wire logic [11:0] i_cmd_addr,
  input wire logic [31:0] i_cmd_data,
  input wire logic i_px_valid,
  input wire logic [PIXEL_W-1:0] i_px_data,
  input wire logic [PIXEL_W-1:0] i_trans_color,
  input wire logic o_px_we,
  input wire logic o_coord_correct_en,
  input wire logic o_filter_select,
  input wire logic [1:0] o_wrap_mode_t,
  input wire logic [1:0] o_wrap_mode_s,
  input wire logic [1:0] o_texel_mix_mode,
  input wire logic [1:0] o_tex_alpha_mode,
  input wire logic [1:0] o_tex_alpha_eff,
  input wire logic o_tex_area_x4,
  input wire logic [1:0] o_poly_blend_sel,
  input wire logic o_transparent_skip_en,
  input wire logic [1:0] o_blend_sel,
  input wire logic [3:0] o_blit_logic_op,
  input wire logic o_gray_shade_unmask,
  input wire logic [25:0] o_frame_origin,
  input wire logic [11:0] o_frame_width_px,
  input wire logic [25:0] o_depth_origin,
  input wire logic [25:0] o_texel_store_origin,
  input wire logic [25:0] o_poly_flag_origin
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // load strobes; mode outputs follow two edges after the command edge
  wire logic ld_tex = i_cmd_valid && (i_cmd_addr == 12'h42C);
  wire logic ld_blit = i_cmd_valid && (i_cmd_addr == 12'h430);
  wire logic ld_gray = i_cmd_valid && (i_cmd_addr == 12'h43C);
  wire logic ld_frame = i_cmd_valid && (i_cmd_addr == 12'h440);
  wire logic ld_wid = i_cmd_valid && (i_cmd_addr == 12'h444);
  wire logic [8:0] tex_v = {o_tex_area_x4, o_tex_alpha_mode,
    o_texel_mix_mode, o_wrap_mode_s, o_wrap_mode_t};

  property p_tex_lo;
    ld_tex |-> ##2 {o_filter_select, o_coord_correct_en} ==
      $past({i_cmd_data[5], i_cmd_data[3]}, 2);
  endproperty
  a_tex_lo: assert property (p_tex_lo) else $error("tex low bits");
  property p_tex_hi;
    ld_tex |-> ##2 tex_v[8:0] == $past({i_cmd_data[24],
      i_cmd_data[21:20], i_cmd_data[17:16], i_cmd_data[11:8]}, 2);
  endproperty
  a_tex_hi: assert property (p_tex_hi) else $error("tex fields");
  property p_tex_hold;
    !ld_tex |-> ##2 $stable(tex_v);
  endproperty
  a_tex_hold: assert property (p_tex_hold) else $error("tex drift");
  // only alpha blending lets the stencil alpha modes through
  property p_alpha_eff;
    o_tex_alpha_eff == ((o_poly_blend_sel == 2'h1) ? o_tex_alpha_mode : 2'h0);
  endproperty
  a_alpha_eff: assert property (p_alpha_eff) else $error("alpha eff");
  property p_blit;
    ld_blit |-> ##2 {o_blit_logic_op, o_blend_sel, o_transparent_skip_en}
      == $past({i_cmd_data[12:7], i_cmd_data[1]}, 2);
  endproperty
  a_blit: assert property (p_blit) else $error("blit fields");
  property p_pixel;
    i_px_valid |=> o_px_we == !(o_transparent_skip_en &&
      ($past(i_px_data) == $past(i_trans_color)));
  endproperty
  a_pixel: assert property (p_pixel) else $error("pixel skip");
  property p_gray;
    ld_gray |-> ##2 o_gray_shade_unmask == $past(i_cmd_data[4], 2);
  endproperty
  a_gray: assert property (p_gray) else $error("gray mask");
  property p_gray_keep;
    !ld_gray |-> ##2 $stable(o_gray_shade_unmask);
  endproperty
  a_gray_keep: assert property (p_gray_keep) else $error("gray kept");
  property p_frame;
    ld_frame |-> ##2 o_frame_origin == {$past(i_cmd_data[25:6], 2), 6'h00};
  endproperty
  a_frame: assert property (p_frame) else $error("frame origin");
  property p_low0;
    (o_depth_origin[5:0] | o_texel_store_origin[5:0] |
      o_poly_flag_origin[5:0]) == 6'h00;
  endproperty
  a_low0: assert property (p_low0) else $error("origin low bits");
  property p_wid;
    ld_wid |-> ##2 o_frame_width_px == $past(i_cmd_data[11:0], 2);
  endproperty
  a_wid: assert property (p_wid) else $error("frame width");
  c_tex: cover property (ld_tex);
  c_skip: cover property (i_px_valid ##1 !o_px_we);
  c_gray: cover property (ld_gray && i_cmd_data[4]);
endmodule

bind drmc_regs drmc_regs_sva #(.PIXEL_W(PIXEL_W)) i_drmc_regs_sva (
  .i_clk_sys, .i_rst, .i_cmd_valid, .i_cmd_addr, .i_cmd_data, .i_px_valid,
  .i_px_data, .i_trans_color, .o_px_we, .o_coord_correct_en,
  .o_filter_select, .o_wrap_mode_t, .o_wrap_mode_s, .o_texel_mix_mode,
  .o_tex_alpha_mode, .o_tex_alpha_eff, .o_tex_area_x4, .o_poly_blend_sel,
  .o_transparent_skip_en, .o_blend_sel, .o_blit_logic_op,
  .o_gray_shade_unmask, .o_frame_origin, .o_frame_width_px,
  .o_depth_origin, .o_texel_store_origin, .o_poly_flag_origin
);
`default_nettype wire

// ==== tb/drmc_cmd_src.sv ====
// partner: drawing command stream issuing register-load commands
// assumes callers enter tasks just after a rising edge of i_clk_sys
`timescale 1ns/1ps
`default_nettype none

module drmc_cmd_src (
  input wire logic i_clk_sys,
  output logic o_cmd_valid,
  output logic [11:0] o_cmd_addr,
  output logic [31:0] o_cmd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_addr = 12'h000;
    o_cmd_data = 32'h0000_0000;
  end
  // one command per call, the only command path into the bank
  task automatic send(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] w;
    w = d;
    // transparency forces source-copy blending
    if (a == 12'h430 && d[1]) begin
      w[8:7] = 2'h0;
    end
    o_cmd_valid = 1'b1;
    o_cmd_addr = a;
    o_cmd_data = w;
    @(posedge i_clk_sys);
    #1;
    o_cmd_valid = 1'b0;
    // released lines carry the inverse so stale data never looks held
    o_cmd_addr = ~a;
    o_cmd_data = ~w;
  endtask
  // gray shading bracket, issued only at 8 bits per pixel
  task automatic gray_mode(input logic on);
    send(12'h43C, on ? 32'h0000_0050 : 32'h0000_0040);
  endtask
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// testbench: scenario tasks for the drawing-mode register bank
// assumes drmc_cmd_src as the command stream and a 200 MHz clock
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic i_clk_sys, i_rst, i_rd_en, i_gray_int_we, i_px_valid;
  logic [11:0] i_rd_addr;
  logic [31:0] i_gray_int_data;
  logic [15:0] i_px_data, i_trans_color;
  wire i_cmd_valid, o_px_we, o_cmd_unmapped, o_rd_valid, o_coord_correct_en;
  wire o_filter_select, o_tex_area_x4, o_tile_en, o_texture_en;
  wire o_transparent_skip_en, o_gray_shade_unmask;
  wire [1:0] o_wrap_mode_t, o_wrap_mode_s, o_texel_mix_mode, o_tex_alpha_mode;
  wire [1:0] o_tex_alpha_eff, o_pattern_source_sel, o_poly_blend_sel;
  wire [1:0] o_blend_sel;
  wire [3:0] o_blit_logic_op;
  wire [11:0] i_cmd_addr, o_frame_width_px;
  wire [31:0] i_cmd_data, o_rd_data, o_gray_ext;
  wire [25:0] o_frame_origin, o_depth_origin;
  wire [25:0] o_texel_store_origin, o_poly_flag_origin;
  wire [15:0] o_px_data;
  wire [10:0] tex_v = {o_tex_area_x4, o_tex_alpha_mode, o_texel_mix_mode,
    o_wrap_mode_s, o_wrap_mode_t, o_filter_select, o_coord_correct_en};
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;

  drmc_cmd_src i_drmc_cmd_src (.i_clk_sys, .o_cmd_valid(i_cmd_valid),
    .o_cmd_addr(i_cmd_addr), .o_cmd_data(i_cmd_data));
  drmc_regs #(.PIXEL_W(16)) i_drmc_regs (.i_clk_sys, .i_rst, .i_cmd_valid,
    .i_cmd_addr, .i_cmd_data, .i_rd_en, .i_rd_addr, .i_gray_int_we,
    .i_gray_int_data, .i_px_valid, .i_px_data, .i_trans_color, .o_px_we,
    .o_px_data, .o_cmd_unmapped, .o_rd_valid, .o_rd_data, .o_coord_correct_en,
    .o_filter_select, .o_wrap_mode_t, .o_wrap_mode_s, .o_texel_mix_mode,
    .o_tex_alpha_mode, .o_tex_alpha_eff, .o_tex_area_x4, .o_pattern_source_sel,
    .o_poly_blend_sel, .o_tile_en, .o_texture_en, .o_transparent_skip_en,
    .o_blend_sel, .o_blit_logic_op, .o_gray_shade_unmask, .o_gray_ext,
    .o_frame_origin, .o_frame_width_px, .o_depth_origin,
    .o_texel_store_origin, .o_poly_flag_origin);

  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end

  // ****************************************************************
  // helpers and scenarios
  // ****************************************************************
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  // mode outputs settle two edges after the command edge
  task automatic load(input logic [11:0] a, input logic [31:0] d);
    i_drmc_cmd_src.send(a, d);
    tick(2);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    i_rd_en = 1'b1;
    i_rd_addr = a;
    tick(1);
    chk(o_rd_valid, 32'h1);
    chk(o_rd_data, exp);
    i_rd_en = 1'b0;
    i_rd_addr = ~a;
    tick(1);
  endtask
  task automatic t_reset();
    chk(o_blit_logic_op, 32'h3);
    chk({o_blend_sel, o_transparent_skip_en}, 32'h0);
    chk(tex_v, 32'h0);
    chk(o_gray_shade_unmask, 32'h0);
  endtask
  task automatic t_poly();
    logic [1:0] b, a;
    for (int i = 0; i < 16; i++) begin
      b = i[1:0];
      a = i[3:2];
      load(12'h428, {2'h0, b, 19'h0, b, 7'h0});
      load(12'h42C, {10'h0, a, 20'h0});
      chk({o_tex_alpha_eff, o_tile_en, o_texture_en},
        {(b == 2'h1) ? a : 2'h0, b == 2'h1, b == 2'h2});
      chk({o_pattern_source_sel, o_poly_blend_sel}, {b, b});
    end
  endtask
  task automatic t_texture();
    load(12'h42C, 32'h8112_0921);
    chk(tex_v, 32'h5A6);
    load(12'h42C, 32'h0021_0608);
    chk(tex_v, 32'h259);
    load(12'h42C, 32'hFFFF_FFFF);
    chk(tex_v, 32'h7FF);
    rd(12'h42C, 32'h0133_0F28);
  endtask
  task automatic t_blit();
    logic [3:0] op;
    for (int i = 0; i < 16; i++) begin
      op = i[3:0];
      load(12'h430, {19'h0, op, 2'h2, 7'h0});
      chk({o_blit_logic_op, o_blend_sel, o_transparent_skip_en},
        {op, 3'h4});
    end
    chk(tex_v, 32'h7FF);
    load(12'h430, 32'h0000_0182);
    chk({o_blit_logic_op, o_blend_sel, o_transparent_skip_en}, 32'h1);
    rd(12'h430, 32'h0000_0002);
    i_trans_color = 16'hA5C3;
    i_px_valid = 1'b1;
    i_px_data = 16'hA5C3;
    tick(1);
    chk(o_px_we, 32'h0);
    i_px_data = 16'hA5C2;
    tick(1);
    chk({o_px_we, o_px_data}, 32'h1_A5C2);
    i_px_valid = 1'b0;
    i_px_data = 16'h5A3D;
    load(12'h430, 32'h0000_0600);
    i_px_valid = 1'b1;
    i_px_data = 16'hA5C3;
    tick(1);
    chk(o_px_we, 32'h1);
    i_px_valid = 1'b0;
  endtask
  task automatic t_gray();
    i_gray_int_we = 1'b1;
    i_gray_int_data = 32'hFFFF_FF00;
    i_drmc_cmd_src.gray_mode(1'b1);
    i_gray_int_we = 1'b0;
    tick(2);
    chk(o_gray_shade_unmask, 32'h1);
    chk(o_gray_ext, 32'hFFFF_FF10);
    i_gray_int_we = 1'b1;
    i_gray_int_data = 32'h0000_0000;
    tick(1);
    i_gray_int_we = 1'b0;
    tick(2);
    chk(o_gray_shade_unmask, 32'h1);
    i_drmc_cmd_src.gray_mode(1'b0);
    tick(2);
    chk(o_gray_shade_unmask, 32'h0);
    rd(12'h43C, 32'h0);
  endtask
  task automatic t_origins();
    logic [11:0] org[4] = '{12'h440, 12'h448, 12'h44C, 12'h450};
    for (int i = 0; i < 4; i++) begin
      load(org[i], 32'hFFFF_FFFF);
      rd(org[i], 32'h03FF_FFC0);
    end
    chk(o_frame_origin | o_depth_origin | o_texel_store_origin |
      o_poly_flag_origin, 32'h03FF_FFC0);
    chk(o_frame_origin & o_depth_origin & o_texel_store_origin &
      o_poly_flag_origin, 32'h03FF_FFC0);
    load(12'h444, 32'hFFFF_FFFF);
    chk(o_frame_width_px, 32'hFFF);
    rd(12'h444, 32'h0000_0FFF);
    i_drmc_cmd_src.send(12'h454, 32'h0000_0000);
    chk(o_cmd_unmapped, 32'h1);
    tick(2);
    chk({o_cmd_unmapped, o_frame_origin}, 32'h03FF_FFC0);
    rd(12'h454, 32'h0);
  endtask

  // cut a hang short well beyond the roughly 230 cycles of traffic
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_rd_en = 1'b0;
    i_rd_addr = 12'h000;
    i_gray_int_we = 1'b0;
    i_gray_int_data = 32'h0000_0000;
    i_px_valid = 1'b0;
    i_px_data = 16'h0000;
    i_trans_color = 16'h0000;
    tick(20);
    i_rst = 1'b0;
    t_reset();
    t_poly();
    t_texture();
    t_blit();
    t_gray();
    t_origins();
    summarize();
  end
endmodule
`default_nettype wire
